// >>> design/tccc_pkg.sv
// tccc_pkg: register map, field layout, reset values and modes of the timer
// assumes an apb slave with 32-bit data, one aligned word per register
package tccc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTL   = 8'h00;  // timer_control_reg
    localparam logic [7:0] OFF_COUNT = 8'h04;  // count_value
    localparam logic [7:0] OFF_CCTL0 = 8'h08;  // channel 0 control
    localparam logic [7:0] OFF_CCR0  = 8'h0C;  // channel_zero_compare_value
    localparam logic [7:0] OFF_CCTL1 = 8'h10;  // channel 1 control
    localparam logic [7:0] OFF_CCR1  = 8'h14;  // channel_compare_value 1
    localparam logic [7:0] OFF_IV    = 8'h18;  // interrupt_vector_reg
    localparam logic [7:0] OFF_CMD   = 8'h1C;  // full-word move vs set/clear

    // timer_control_reg fields
    localparam int CTL_IFG = 0;   // overflow_flag
    localparam int CTL_IE  = 1;
    localparam int CTL_CLR = 2;   // counter_clear_bit, self clearing
    localparam int CTL_MC  = 4;   // mode, 2 bits
    localparam int CTL_ID  = 6;   // input_divider_field, 2 bits
    localparam int CTL_SS  = 8;   // clock source select, 2 bits
    localparam logic [9:0] CTL_RST = 10'h000;

    // channel control fields
    localparam int CC_IFG = 0;
    localparam int CC_IE  = 1;
    localparam int CC_CAP = 2;    // 1 = capture mode
    localparam int CC_SEL = 3;    // capture input select a/b
    localparam int CC_CM  = 4;    // capture edge, 2 bits
    localparam logic [5:0] CC_RST = 6'h00;

    // write command kinds for timer_control_reg
    localparam logic [1:0] WCMD_MOV = 2'h0;
    localparam logic [1:0] WCMD_BIS = 2'h1;
    localparam logic [1:0] WCMD_BIC = 2'h2;

    // interrupt vector codes
    localparam logic [3:0] IV_NONE = 4'h0;
    localparam logic [3:0] IV_CC1  = 4'h2;
    localparam logic [3:0] IV_OVF  = 4'hA;

    typedef enum logic [1:0] {
        TCCC_STOP = 2'h0,
        TCCC_UP   = 2'h1,
        TCCC_CONT = 2'h2,
        TCCC_UPDN = 2'h3
    } tccc_mode_t;

    // counter clock sources
    localparam logic [1:0] SRC_EXT = 2'h0;  // external_timer_clock
    localparam logic [1:0] SRC_AUX = 2'h1;
    localparam logic [1:0] SRC_SUB = 2'h2;  // subsystem_clock
    localparam logic [1:0] SRC_INV = 2'h3;  // inverted_external_clock

    // pin group sampled into the bus clock domain
    typedef struct packed {
        logic       ext_clk;
        logic       inv_clk;
        logic       sub_clk;
        logic       aux_clk;
        logic [1:0] cap_a;
        logic [1:0] cap_b;
    } tccc_pins_t;

    // apb request group
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tccc_apb_req_t;

endpackage

// >>> design/tccc_timer.sv
// tccc_timer: 16-bit timer with two capture/compare channels on apb
// assumes every clock source and capture pin is asynchronous to i_mclk
//
// Overview of operation
// - slow clock, compare bumped by one on match misses next match
// - after a clear, first increment on first source edge, divider ignored
// - all later increments honour the input divider ratio
// - counter clock chosen from four sources by a two-bit field
// - channel zero input b is a pin, not the auxiliary clock
// - up mode sets overflow flag on wrap from channel zero value
// - stop at compare, clear, restart up: next edge sets overflow flag
// - watchdog reset plus compare change may corrupt control and vector
// - full-word move write initialises control and clears vector
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module tccc_timer
    import tccc_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_wdt_reset,
    input  wire tccc_pkg::tccc_pins_t  i_pins,
    input  wire tccc_pkg::tccc_apb_req_t i_apb,
    output logic [31:0]                o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    output logic                       o_irq
);
    import tccc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    tccc_pins_t sync1_reg;
    tccc_pins_t sync2_reg;
    tccc_pins_t prev_reg;

    always_ff @(posedge i_mclk)
    begin
        sync1_reg <= i_pins;
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [9:0]  ctl_reg,   ctl_next;
    logic [15:0] cnt_reg,   cnt_next;
    logic [2:0]  div_reg,   div_next;
    logic        first_reg, first_next;
    logic        down_reg,  down_next;
    logic        wdt_reg,   wdt_next;
    logic        stale_reg, stale_next;  // cleared while stopped at top
    logic [1:0]  miss_reg,  miss_next;   // compare bumped while matching
    logic [5:0]  cc_reg   [2];
    logic [5:0]  cc_next  [2];
    logic [15:0] ccr_reg  [2];
    logic [15:0] ccr_next [2];
    logic [3:0]  iv_reg,    iv_next;
    logic [1:0]  wcmd_reg,  wcmd_next;
    logic [31:0] rdata_reg, rdata_next;

    // rising edge of the selected timer clock, from synced samples
    function automatic logic src_edge(input tccc_pins_t c,
                                      input tccc_pins_t p,
                                      input logic [1:0] s);
        logic a;
        logic b;
        a = 1'b0;
        b = 1'b0;
        case (s)
            SRC_EXT: begin a = c.ext_clk;  b = p.ext_clk;  end
            SRC_AUX: begin a = c.aux_clk;  b = p.aux_clk;  end
            SRC_SUB: begin a = c.sub_clk;  b = p.sub_clk;  end
            default: begin a = ~c.inv_clk; b = ~p.inv_clk; end
        endcase
        return a & ~b;
    endfunction

    // divider terminal count for the input_divider_field
    function automatic logic [2:0] div_max(input logic [1:0] id);
        return 3'((4'h1 << id) - 4'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic        tick;
    logic        wr;
    logic        rd;
    logic [7:0]  a;
    tccc_mode_t  mode;
    logic        cap_ev   [2];
    logic        cap_lvl  [2];
    logic        cap_prv  [2];
    logic        ovf_set;
    logic        cc_set   [2];

    always_comb
    begin
        ctl_next   = ctl_reg;
        cnt_next   = cnt_reg;
        div_next   = div_reg;
        first_next = first_reg;
        down_next  = down_reg;
        wdt_next   = wdt_reg | i_wdt_reset;
        cc_next    = cc_reg;
        ccr_next   = ccr_reg;
        iv_next    = iv_reg;
        wcmd_next  = wcmd_reg;
        rdata_next = rdata_reg;
        stale_next = stale_reg;
        miss_next  = miss_reg;
        ovf_set    = 1'b0;
        tick       = 1'b0;
        a          = i_apb.paddr;
        wr = i_apb.psel & i_apb.penable & i_apb.pwrite;
        rd = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
        mode = tccc_mode_t'(ctl_reg[CTL_MC +: 2]);

        // counter clocking through the divider
        if (mode != TCCC_STOP &&
            src_edge(sync2_reg, prev_reg, ctl_reg[CTL_SS +: 2]))
        begin
            if (first_reg)
            begin
                tick       = 1'b1;
                first_next = 1'b0;
            end
            else if (div_reg == div_max(ctl_reg[CTL_ID +: 2]))
            begin
                tick     = 1'b1;
                div_next = 3'h0;
            end
            else
                div_next = div_reg + 3'h1;
        end

        if (tick)
        begin
            // stale wrap check after clear at compare value
            if (mode == TCCC_UP &&
                (cnt_reg == ccr_reg[0] || first_reg))
            begin
                if (cnt_reg == ccr_reg[0] || (first_reg && stale_reg))
                    ovf_set = 1'b1;
                cnt_next = (cnt_reg == ccr_reg[0]) ? 16'h0000
                                                   : cnt_reg + 16'h1;
            end
            else if (mode == TCCC_UPDN)
            begin
                if (cnt_reg == ccr_reg[0]) down_next = 1'b1;
                if (down_reg && cnt_reg == 16'h0001)
                begin
                    down_next = 1'b0;
                    ovf_set   = 1'b1;
                end
                cnt_next = (down_reg || cnt_reg == ccr_reg[0])
                           ? cnt_reg - 16'h1 : cnt_reg + 16'h1;
            end
            else
            begin
                if (cnt_reg == 16'hFFFF) ovf_set = 1'b1;
                cnt_next = cnt_reg + 16'h1;
            end
            down_next  = (mode == TCCC_UP) ? 1'b0 : down_next;
            stale_next = 1'b0;
        end

        // channels: compare only on a count change; a compare value bumped
        // at a match in compare mode skips the next match through miss_reg
        for (int i = 0; i < 2; i++)
        begin
            // channel zero input b comes only from its pin
            cap_lvl[i] = cc_reg[i][CC_SEL] ? sync2_reg.cap_b[i]
                                           : sync2_reg.cap_a[i];
            cap_prv[i] = cc_reg[i][CC_SEL] ? prev_reg.cap_b[i]
                                           : prev_reg.cap_a[i];
            cap_ev[i]  = (cc_reg[i][CC_CM] & cap_lvl[i] & ~cap_prv[i]) |
                         (cc_reg[i][CC_CM+1] & ~cap_lvl[i] & cap_prv[i]);
            cc_set[i] = 1'b0;
            if (tick)
                miss_next[i] = 1'b0;
            if (cc_reg[i][CC_CAP])
            begin
                if (cap_ev[i])
                begin
                    ccr_next[i] = cnt_reg;
                    cc_set[i]   = 1'b1;
                end
            end
            else if (tick && cnt_next == ccr_reg[i]
                     && cnt_next != cnt_reg && !miss_reg[i])
                cc_set[i] = 1'b1;
        end

        // register writes; hardware sets above win over software clears
        if (wr)
        begin
            case (a)
                OFF_CMD: wcmd_next = i_apb.pwdata[1:0];
                OFF_CTL:
                begin
                    if (wcmd_reg == WCMD_BIS)
                        ctl_next = ctl_reg | i_apb.pwdata[9:0];
                    else if (wcmd_reg == WCMD_BIC)
                        ctl_next = ctl_reg & ~i_apb.pwdata[9:0];
                    else
                    begin
                        ctl_next = i_apb.pwdata[9:0];
                        iv_next  = IV_NONE;
                        wdt_next = 1'b0;
                    end
                end
                OFF_COUNT: cnt_next = i_apb.pwdata[15:0];
                OFF_CCTL0: cc_next[0] = i_apb.pwdata[5:0];
                OFF_CCTL1: cc_next[1] = i_apb.pwdata[5:0];
                OFF_CCR0, OFF_CCR1:
                begin
                    ccr_next[a[4]] = i_apb.pwdata[15:0];
                    // bumped while matching, next match is lost
                    miss_next[a[4]] = !cc_reg[a[4]][CC_CAP]
                                      && cnt_reg == ccr_reg[a[4]];
                    // latent corruption after a watchdog reset
                    if (wdt_reg)
                    begin
                        ctl_next = ctl_next ^ i_apb.pwdata[9:0];
                        iv_next  = iv_reg ^ i_apb.pwdata[3:0];
                    end
                end
                default: ;
            endcase
        end

        // hardware flag sets win over a software clear in one cycle
        ctl_next[CTL_IFG] = ctl_next[CTL_IFG] | ovf_set;
        for (int i = 0; i < 2; i++)
            cc_next[i][CC_IFG] = cc_next[i][CC_IFG] | cc_set[i];

        // clear zeros counter and divider, re-arms first tick
        if (ctl_next[CTL_CLR])
        begin
            // remember a clear taken while stopped at the top value
            stale_next        = (mode == TCCC_STOP)
                                && (cnt_reg == ccr_reg[0]);
            cnt_next          = 16'h0000;
            div_next          = 3'h0;
            first_next        = 1'b1;
            ctl_next[CTL_CLR] = 1'b0;
        end

        // read data; reading the vector leaves its source pending
        if (rd)
        begin
            case (a)
                OFF_CTL:   rdata_next = {22'h0, ctl_reg};
                OFF_COUNT: rdata_next = {16'h0, cnt_reg};
                OFF_CCTL0: rdata_next = {26'h0, cc_reg[0]};
                OFF_CCR0:  rdata_next = {16'h0, ccr_reg[0]};
                OFF_CCTL1: rdata_next = {26'h0, cc_reg[1]};
                OFF_CCR1:  rdata_next = {16'h0, ccr_reg[1]};
                OFF_IV:    rdata_next = {28'h0, iv_reg};
                OFF_CMD:   rdata_next = {30'h0, wcmd_reg};
                default:   rdata_next = 32'h0000_0000;
            endcase
        end

        // vector takes channel 1 before overflow and holds while any is pending; channel 0 never enters
        if (!(wr && wcmd_reg == WCMD_MOV && a == OFF_CTL))
        begin
            if (cc_next[1][CC_IFG] & cc_next[1][CC_IE])
                iv_next = (iv_reg == IV_NONE) ? IV_CC1 : iv_next;
            else if (ctl_next[CTL_IFG] & ctl_next[CTL_IE])
                iv_next = (iv_reg == IV_NONE) ? IV_OVF : iv_next;
            else if (!wdt_reg)
                iv_next = IV_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            ctl_reg   <= CTL_RST;
            cnt_reg   <= 16'h0000;
            div_reg   <= 3'h0;
            first_reg <= 1'b1;
            down_reg  <= 1'b0;
            wdt_reg   <= 1'b0;
            stale_reg <= 1'b0;
            miss_reg  <= 2'h0;
            cc_reg    <= '{CC_RST, CC_RST};
            ccr_reg   <= '{16'h0000, 16'h0000};
            iv_reg    <= IV_NONE;
            wcmd_reg  <= WCMD_MOV;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ctl_reg   <= ctl_next;
            cnt_reg   <= cnt_next;
            div_reg   <= div_next;
            first_reg <= first_next;
            down_reg  <= down_next;
            wdt_reg   <= wdt_next;
            stale_reg <= stale_next;
            miss_reg  <= miss_next;
            cc_reg    <= cc_next;
            ccr_reg   <= ccr_next;
            iv_reg    <= iv_next;
            wcmd_reg  <= wcmd_next;
            rdata_reg <= rdata_next;
        end
    end

    // outputs: zero-wait slave, read data registered in setup
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_prdata  = rdata_reg;
    assign o_irq     = (iv_reg != IV_NONE);

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_clear_self_ends: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) !ctl_reg[CTL_CLR])
        else $error("clear bit stayed set");
    a_clear_zeros_cnt: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (wr && a == OFF_CTL && i_apb.pwdata[CTL_CLR]
         && wcmd_reg != WCMD_BIC) |=> cnt_reg == 16'h0000)
        else $error("clear did not zero counter");
    a_first_tick_fast: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (first_reg && mode != TCCC_STOP && !ctl_next[CTL_CLR] &&
         src_edge(sync2_reg, prev_reg, ctl_reg[CTL_SS +: 2])) |=> !first_reg)
        else $error("first increment waited on divider");
    a_divider_ratio: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (tick && !first_reg) |-> div_reg == div_max(ctl_reg[CTL_ID +: 2]))
        else $error("increment off divider ratio");
    a_up_wrap_flag: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (tick && mode == TCCC_UP && cnt_reg == ccr_reg[0])
        |=> ctl_reg[CTL_IFG] && cnt_reg == 16'h0000)
        else $error("up wrap missed overflow flag");
    a_stale_restart: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (tick && first_reg && stale_reg && mode == TCCC_UP)
        |=> ctl_reg[CTL_IFG])
        else $error("restart after clear at top missed flag");
    a_move_clears_iv: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (wr && a == OFF_CTL && wcmd_reg == WCMD_MOV)
        |=> iv_reg == IV_NONE && !wdt_reg)
        else $error("move write left vector");
    a_no_skip_match: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (wr && a == OFF_CCR1 && !cc_reg[1][CC_CAP] && !tick)
        |=> !$rose(cc_reg[1][CC_IFG]) || $past(cnt_reg) != cnt_reg)
        else $error("compare flag without count change");
    a_corrupt_gated: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (wr && (a == OFF_CCR0 || a == OFF_CCR1) && !wdt_reg && !tick
         && !cc_reg[0][CC_IFG] && !cc_reg[1][CC_IFG])
        |=> $stable(ctl_reg[9:4]))
        else $error("control changed by compare write");

    c_up_wrap:   cover property (@(posedge i_mclk)
        tick && mode == TCCC_UP && cnt_reg == ccr_reg[0]);
    c_stale_ovf: cover property (@(posedge i_mclk)
        tick && first_reg && stale_reg && mode == TCCC_UP);
    c_capture:   cover property (@(posedge i_mclk)
        cc_reg[0][CC_CAP] && cap_ev[0]);
    c_wdt_bump:  cover property (@(posedge i_mclk)
        wdt_reg && wr && a == OFF_CCR1);

endmodule

// >>> test/tccc_timer_tb_top.sv
// tccc_timer_tb_top: self-checking bench for the capture/compare timer
// assumes tccc_pkg map, zero-wait apb slave, pins synced in 2 flops
`timescale 1ns/1ps
module tccc_timer_tb_top;
    import tccc_pkg::*;

    localparam int P_EXT = 7;
    localparam int P_INV = 6;
    localparam int P_SUB = 5;
    localparam int P_AUX = 4;
    localparam int P_CB0 = 0;

    logic                   i_mclk;
    logic                   i_sys_rst;
    logic                   wdt_rst;
    logic [7:0]             pin_vec;
    tccc_apb_req_t          apb;
    logic [31:0]            o_prdata;
    logic                   o_pready;
    logic                   o_pslverr;
    logic                   o_irq;
    int                     fail_count;
    int                     n_compared;
    logic [31:0]            rd;

    tccc_timer dut_u (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_wdt_reset (wdt_rst),
        .i_pins      (tccc_pins_t'(pin_vec)),
        .i_apb       (apb),
        .o_prdata    (o_prdata),
        .o_pready    (o_pready),
        .o_pslverr   (o_pslverr),
        .o_irq       (o_irq)
    );

    // 25 MHz clock
    always #20 i_mclk = ~i_mclk;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d);
        @(posedge i_mclk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_mclk);
        apb.penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1)
            @(posedge i_mclk);
        rd = o_prdata;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    // n full low-high-low pulses on a pin, each long enough to be synced
    task automatic pulse(input int b, input int n);
        repeat (n)
        begin
            @(posedge i_mclk);
            pin_vec[b] <= 1'b1;
            repeat (4) @(posedge i_mclk);
            pin_vec[b] <= 1'b0;
            repeat (6) @(posedge i_mclk);
        end
    endtask

    function automatic logic [31:0] ctl(logic [1:0] md, logic [1:0] id,
                                        logic [1:0] ss, logic ie, logic clr);
        ctl = 32'h0;
        ctl[CTL_MC+:2] = md;
        ctl[CTL_ID+:2] = id;
        ctl[CTL_SS+:2] = ss;
        ctl[CTL_IE]    = ie;
        ctl[CTL_CLR]   = clr;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // scenarios

    task automatic t_reset_map();
        rchk("ctl", OFF_CTL, 32'h0);
        rchk("count", OFF_COUNT, 32'h0);
        rchk("iv", OFF_IV, 32'h0);
        rchk("cctl1", OFF_CCTL1, 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h20, 32'h0);
        check("pslverr", {31'h0, o_pslverr}, 32'h0);
        $display("test reset_map done");
    endtask

    // first tick ignores divider, later ticks every fourth edge
    task automatic t_divider();
        wr(OFF_CCR0, 32'h0000_FFFF);
        wr(OFF_CTL, ctl(TCCC_UP, 2'h2, SRC_SUB, 1'b0, 1'b1));
        rchk("clr_self", OFF_CTL, ctl(TCCC_UP, 2'h2, SRC_SUB, 1'b0, 1'b0));
        rchk("cnt_clr", OFF_COUNT, 32'h0);
        pulse(P_SUB, 1);
        rchk("cnt_first", OFF_COUNT, 32'h1);
        pulse(P_SUB, 3);
        rchk("cnt_div3", OFF_COUNT, 32'h1);
        pulse(P_SUB, 1);
        rchk("cnt_div4", OFF_COUNT, 32'h2);
        $display("test divider done");
    endtask

    // each source counts its own pin and ignores another
    task automatic t_sources();
        int pin_of [4];
        int other;
        pin_of = '{P_EXT, P_AUX, P_SUB, P_INV};
        for (int s = 0; s < 4; s++)
        begin
            other = (s == 2) ? P_EXT : P_SUB;
            wr(OFF_CTL, ctl(TCCC_CONT, 2'h0, 2'(s), 1'b0, 1'b1));
            pulse(other, 1);
            pulse(pin_of[s], 1);
            rchk("cnt_src", OFF_COUNT, 32'h1);
        end
        $display("test sources done");
    endtask

    // stale overflow after restart, then proper wrap in up mode
    task automatic t_overflow();
        wr(OFF_CCR0, 32'h0000_0002);
        wr(OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b1));
        pulse(P_SUB, 2);
        rchk("cnt_top", OFF_COUNT, 32'h2);
        rchk("ifg_top", OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b0));
        wr(OFF_CTL, ctl(TCCC_STOP, 2'h0, SRC_SUB, 1'b1, 1'b0));
        wr(OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b1));
        rchk("ifg_rst", OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b0));
        pulse(P_SUB, 1);
        rchk("cnt_rs", OFF_COUNT, 32'h1);
        rchk("ifg_stale", OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b0)
             | 32'h1);
        wr(OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b0));
        pulse(P_SUB, 1);
        rchk("ifg_no", OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b0));
        pulse(P_SUB, 1);
        rchk("cnt_wrap", OFF_COUNT, 32'h0);
        rchk("ifg_wrap", OFF_CTL, ctl(TCCC_UP, 2'h0, SRC_SUB, 1'b1, 1'b0)
             | 32'h1);
        check("irq_ovf", {31'h0, o_irq}, 32'h1);
        rchk("iv_ovf", OFF_IV, {28'h0, IV_OVF});
        wr(OFF_CTL, 32'h0);
        $display("test overflow done");
    endtask

    // compare bumped by one at a match misses; capture detour does not
    task automatic t_bump();
        wr(OFF_CCR0, 32'h0000_FFFF);
        wr(OFF_CCTL1, 32'h2);
        wr(OFF_CCR1, 32'h3);
        wr(OFF_CTL, ctl(TCCC_CONT, 2'h0, SRC_EXT, 1'b0, 1'b1));
        pulse(P_EXT, 3);
        rchk("cc1_hit", OFF_CCTL1, 32'h3);
        wr(OFF_CCTL1, 32'h2);
        wr(OFF_CCR1, 32'h4);
        pulse(P_EXT, 1);
        rchk("cc1_miss", OFF_CCTL1, 32'h2);
        wr(OFF_CCTL1, 32'h6);
        wr(OFF_CCR1, 32'h5);
        wr(OFF_CCTL1, 32'h2);
        pulse(P_EXT, 1);
        rchk("cc1_fix", OFF_CCTL1, 32'h3);
        rchk("iv_cc1", OFF_IV, {28'h0, IV_CC1});
        wr(OFF_CCTL1, 32'h0);
        $display("test bump done");
    endtask

    // channel 0 input b sees its pin, not the auxiliary clock
    task automatic t_cap_b();
        wr(OFF_CCTL0, 32'h1C);
        pulse(P_AUX, 2);
        rchk("cc0_aux", OFF_CCTL0, 32'h1C);
        pulse(P_CB0, 1);
        rchk("cc0_pin", OFF_CCTL0, 32'h1D);
        wr(OFF_CCTL0, 32'h0);
        $display("test cap_b done");
    endtask

    // watchdog marker, compare write corrupts, full move write restores
    task automatic t_wdt();
        @(posedge i_mclk);
        wdt_rst <= 1'b1;
        @(posedge i_mclk);
        wdt_rst <= 1'b0;
        // stop by a bit-clear write, which keeps the watchdog marker
        wr(OFF_CMD, {30'h0, WCMD_BIC});
        wr(OFF_CTL, 32'h0000_03FF);
        wr(OFF_CCR1, 32'h5);
        apb_xfer(1'b0, OFF_CTL, 32'h0);
        check("ctl_bad", {31'h0, rd != 32'h0}, 32'h1);
        wr(OFF_CMD, {30'h0, WCMD_MOV});
        wr(OFF_CTL, 32'h0);
        rchk("ctl_mov", OFF_CTL, 32'h0);
        rchk("iv_mov", OFF_IV, 32'h0);
        check("irq_mov", {31'h0, o_irq}, 32'h0);
        $display("test wdt done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // run control

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog against a hung bench
    initial
    begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        finish_test();
    end

    initial
    begin
        i_mclk     = 1'b0;
        i_sys_rst  = 1'b1;
        wdt_rst    = 1'b0;
        pin_vec    = 8'h00;
        apb        = '0;
        fail_count = 0;
        n_compared = 0;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        t_reset_map();
        t_divider();
        t_sources();
        t_overflow();
        t_bump();
        t_cap_b();
        t_wdt();
        finish_test();
    end
endmodule
